// ### hdl/clock_gen_pkg.sv
// Shared constants, types and register map of the clock generator control.
// Assumes one 50 MHz system clock; oscillator and subclock arrive as pulses.
package clock_gen_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam int          ADDR_W           = 28;
    localparam int          DATA_W           = 8;
    localparam logic [27:0] LOOP_CONTROL_ADR = 28'hffff806;
    localparam logic [27:0] PROC_CLK_CTL_ADR = 28'hffff828;
    localparam logic [27:0] PROT_CMD_ADR     = 28'hffff1fc;
    localparam logic [7:0]  PROC_CLK_CTL_RST = 8'h03;
    localparam logic [7:0]  LOOP_CONTROL_RST = 8'h01;

    // Processor clock control fields
    localparam int SUB_FB_OFF_BIT  = 7;
    localparam int MAIN_OSC_STOP_B = 6;
    localparam int MAIN_FB_OFF_BIT = 5;
    localparam int CLK_STATUS_BIT  = 4;
    localparam int CLK_SEL_TOP_BIT = 3;
    localparam int CLK_DIV_MSB     = 2;

    // Loop control fields
    localparam int LOOP_RUN_BIT    = 0;
    localparam int LOOP_SEL_BIT    = 1;
    localparam int RT_SECURITY_BIT = 2;

    // ********************************************************
    // Clock figures
    // ********************************************************
    localparam int SYS_CLK_HZ    = 50_000_000;
    localparam int WATCH_HZ      = 32_768;
    localparam int OSC_HZ_DFLT   = 5_000_000;
    localparam int OST_TIME_US   = 328;
    localparam int OST_CYCLES    = OST_TIME_US * (SYS_CLK_HZ / 1_000_000);
    localparam int PERIPH_TAPS   = 11;
    localparam int SYS_DIV_TAPS  = 6;
    localparam int PLL_MULT      = 4;
    localparam int PERIOD_W      = 16;
    localparam int NCO_W         = 24;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_HALT,
        PWR_IDLE,
        PWR_STOP
    } pwr_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic                   cpu;
        logic                   sys;
        logic                   fxx;
        logic                   watch;
        logic [PERIPH_TAPS-1:0] periph;
    } clk_ticks_t;

endpackage

// ### hdl/clock_gen_ctrl.sv
// Clock generator control: register file, oscillator control, x4 loop,
// prescalers, system clock selector and clock output pin.
// Assumes oscillator and subclock edges arrive as one-cycle pulses of i_clk.
//
// Behaviour
// - Main oscillator stops in STOP, or when stop bit set on subclock.
// - Peripheral prescaler gives fxx down to fxx/1024.
// - Selector takes fxx to fxx/32 from the same prescaler for CPU and system clock.
// - Raw oscillator divided to 32.768 kHz for the watch timer.
// - Loop outputs oscillator as is or times four per select bit.
// - Loop run bit starts or stops the loop while the main oscillator runs.
// - Clock control write accepted only right after protection write.
// - Clock control register is 8 bits, resets to 03h.
// - Bit 7 disables the subclock feedback resistor.
// - Bit 4 is read-only status, 1 when CPU runs on subclock.
// - Select 0000-0101 divide by 1..32, 011x prohibited, 1xxx subclock.
// - Source switch completes within one subclock period, status follows.
// - HALT stops CPU only; IDLE stops all but oscillator, loop and watch clock; STOP stops them.
// - Subclock with main stopped halts peripherals; sub-IDLE stops CPU.
// - Clock output carries system clock when running, low when stopped.
// - Clock output stays high impedance until configured.
// - Stabilisation time inserted on every main clock start.
// - Loop control bits 7-3 read zero, resets to 01h.
`timescale 1ns/100ps
`default_nettype none

module clock_gen_ctrl #(
    parameter int OSC_HZ     = clock_gen_pkg::OSC_HZ_DFLT,
    parameter int OST_COUNT  = clock_gen_pkg::OST_CYCLES
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_resetn,
    input  wire clock_gen_pkg::reg_req_t  i_req,
    output logic [clock_gen_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                     i_osc_tick,
    input  wire logic                     i_sub_tick,
    input  wire clock_gen_pkg::pwr_mode_t i_power_mode,
    input  wire logic                     i_system_clock_out_pin_enable,
    output logic                          o_main_osc_run,
    output logic                          o_osc_stable,
    output logic                          o_loop_running,
    output logic                          o_sub_feedback_off,
    output logic                          o_main_feedback_off,
    output logic                          o_realtime_out_security,
    output clock_gen_pkg::clk_ticks_t     o_ticks,
    output logic                          o_system_clock_out_pin,
    output logic                          o_system_clock_out_pin_oe
);
    import clock_gen_pkg::*;

    localparam int OST_W = $clog2(OST_COUNT + 1);

    // ********************************************************
    // Register file
    // ********************************************************
    logic             unlock_q;
    logic             sub_fb_off_q;
    logic             main_osc_stop_q;
    logic             main_fb_off_q;
    logic             status_q;
    logic [3:0]       clk_sel_q;
    logic             loop_run_q;
    logic             loop_sel_q;
    logic             rt_sec_q;
    logic [7:0]       rdata_q;
    logic             clk_ctl_wr;
    logic             sel_ok;

    assign clk_ctl_wr = i_req.wr && (i_req.addr == PROC_CLK_CTL_ADR);
    // Prohibited 011x divider codes are dropped, the old setting stays
    assign sel_ok = i_req.wdata[CLK_SEL_TOP_BIT] ||
                    (i_req.wdata[CLK_DIV_MSB:1] != 2'b11);

    // Any write other than the protection command re-arms the lock
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            unlock_q <= 1'b0;
        end else if (i_req.wr) begin
            unlock_q <= (i_req.addr == PROT_CMD_ADR);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sub_fb_off_q    <= PROC_CLK_CTL_RST[SUB_FB_OFF_BIT];
            main_osc_stop_q <= PROC_CLK_CTL_RST[MAIN_OSC_STOP_B];
            main_fb_off_q   <= PROC_CLK_CTL_RST[MAIN_FB_OFF_BIT];
            clk_sel_q       <= PROC_CLK_CTL_RST[3:0];
        end else if (clk_ctl_wr && unlock_q) begin
            sub_fb_off_q    <= i_req.wdata[SUB_FB_OFF_BIT];
            main_osc_stop_q <= i_req.wdata[MAIN_OSC_STOP_B];
            main_fb_off_q   <= i_req.wdata[MAIN_FB_OFF_BIT];
            if (sel_ok) begin
                clk_sel_q <= i_req.wdata[3:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            loop_run_q <= LOOP_CONTROL_RST[LOOP_RUN_BIT];
            loop_sel_q <= LOOP_CONTROL_RST[LOOP_SEL_BIT];
            rt_sec_q   <= LOOP_CONTROL_RST[RT_SECURITY_BIT];
        end else if (i_req.wr && (i_req.addr == LOOP_CONTROL_ADR)) begin
            loop_run_q <= i_req.wdata[LOOP_RUN_BIT];
            loop_sel_q <= i_req.wdata[LOOP_SEL_BIT];
            rt_sec_q   <= i_req.wdata[RT_SECURITY_BIT];
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_q <= 8'h00;
        end else if (!i_req.rd) begin
            rdata_q <= 8'h00;
        end else if (i_req.addr == PROC_CLK_CTL_ADR) begin
            rdata_q <= {sub_fb_off_q, main_osc_stop_q, main_fb_off_q,
                        status_q, clk_sel_q};
        end else if (i_req.addr == LOOP_CONTROL_ADR) begin
            rdata_q <= {5'h00, rt_sec_q, loop_sel_q, loop_run_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ********************************************************
    // Oscillator control and stabilisation
    // ********************************************************
    logic             osc_on;
    logic             osc_on_q;
    logic [OST_W-1:0] ost_cnt_q;
    logic             stable_q;
    logic             osc_ok;

    assign osc_on = (i_power_mode != PWR_STOP) &&
                    !(main_osc_stop_q && status_q);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            osc_on_q <= 1'b0;
        end else begin
            osc_on_q <= osc_on;
        end
    end

    // Counter restarts on every start, external clock or crystal alike
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ost_cnt_q <= '0;
            stable_q  <= 1'b0;
        end else if (!osc_on_q) begin
            ost_cnt_q <= '0;
            stable_q  <= 1'b0;
        end else if (ost_cnt_q == OST_W'(OST_COUNT)) begin
            stable_q  <= 1'b1;
        end else begin
            ost_cnt_q <= ost_cnt_q + 1'b1;
        end
    end

    assign osc_ok = i_osc_tick && stable_q && osc_on_q;

    // ********************************************************
    // Times-four loop
    // ********************************************************
    // Period is measured between oscillator pulses; needs at least
    // PLL_MULT system cycles per oscillator period to space the pulses.
    logic [PERIOD_W-1:0] since_q;
    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] quarter;
    logic                loop_live;
    logic                pll_tick;

    assign loop_live = loop_run_q && osc_on_q;
    assign quarter   = period_q >> 2;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            since_q  <= '0;
            period_q <= '0;
        end else if (!loop_live) begin
            since_q  <= '0;
            period_q <= '0;
        end else if (i_osc_tick) begin
            since_q  <= PERIOD_W'(1);
            period_q <= since_q;
        end else if (since_q != '1) begin
            since_q  <= since_q + 1'b1;
        end
    end

    always_comb begin
        pll_tick = 1'b0;
        if (loop_live && (quarter != '0)) begin
            pll_tick = osc_ok || (stable_q && ((since_q == quarter) ||
                       (since_q == PERIOD_W'(2 * quarter)) ||
                       (since_q == PERIOD_W'(3 * quarter))));
        end
    end

    // ********************************************************
    // Prescalers and selector
    // ********************************************************
    logic                   fxx;
    logic                   main_run;
    logic [PERIPH_TAPS-2:0] div_q;
    logic [PERIPH_TAPS-1:0] tap;
    logic                   sys_tick;
    logic                   sys_run;

    assign fxx      = loop_sel_q ? (pll_tick && loop_live) : osc_ok;
    assign main_run = (i_power_mode == PWR_RUN) ||
                      (i_power_mode == PWR_HALT);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            div_q <= '0;
        end else if (fxx && main_run) begin
            div_q <= div_q + 1'b1;
        end
    end

    // All taps share one counter, so a tap change cannot shorten a pulse
    generate
        for (genvar k = 0; k < PERIPH_TAPS; k++) begin : g_tap
            if (k == 0) begin : g_raw
                assign tap[k] = fxx && main_run;
            end else begin : g_div
                assign tap[k] = fxx && main_run && (&div_q[k-1:0]);
            end
        end
    endgenerate

    // Source changes only on a subclock pulse: one subclock period at most
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            status_q <= 1'b0;
        end else if (i_sub_tick) begin
            status_q <= clk_sel_q[CLK_SEL_TOP_BIT];
        end
    end

    always_comb begin
        sys_tick = 1'b0;
        if (status_q) begin
            sys_tick = i_sub_tick && main_run;
        end else if (clk_sel_q[CLK_DIV_MSB:0] < 3'(SYS_DIV_TAPS)) begin
            sys_tick = tap[clk_sel_q[CLK_DIV_MSB:0]];
        end
    end

    assign sys_run = main_run && (status_q || stable_q);

    // ********************************************************
    // Watch timer clock
    // ********************************************************
    logic [NCO_W-1:0] nco_q;
    logic [NCO_W-1:0] nco_sum;
    logic             watch_tick;

    assign nco_sum    = nco_q + NCO_W'(WATCH_HZ);
    assign watch_tick = osc_ok && (nco_sum >= NCO_W'(OSC_HZ));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            nco_q <= '0;
        end else if (watch_tick) begin
            nco_q <= nco_sum - NCO_W'(OSC_HZ);
        end else if (osc_ok) begin
            nco_q <= nco_sum;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_ticks <= '0;
        end else begin
            o_ticks.cpu    <= sys_tick && (i_power_mode == PWR_RUN);
            o_ticks.sys    <= sys_tick;
            o_ticks.fxx    <= tap[0];
            o_ticks.watch  <= watch_tick;
            o_ticks.periph <= tap;
        end
    end

    // Pin toggles per system pulse and is held low while stopped
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_system_clock_out_pin    <= 1'b0;
            o_system_clock_out_pin_oe <= 1'b0;
        end else begin
            o_system_clock_out_pin_oe <= i_system_clock_out_pin_enable;
            if (!sys_run) begin
                o_system_clock_out_pin <= 1'b0;
            end else if (sys_tick) begin
                o_system_clock_out_pin <= !o_system_clock_out_pin;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_main_osc_run <= 1'b0;
            o_loop_running <= 1'b0;
        end else begin
            o_main_osc_run <= osc_on;
            o_loop_running <= loop_run_q && osc_on;
        end
    end

    assign o_osc_stable            = stable_q;
    assign o_sub_feedback_off      = sub_fb_off_q;
    assign o_main_feedback_off     = main_fb_off_q;
    assign o_realtime_out_security = rt_sec_q;
    assign o_rdata                 = rdata_q;

    // ********************************************************
    // Checks
    // ********************************************************
    AST_OSC_STOP_MODE: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (i_power_mode == PWR_STOP) |=> !o_main_osc_run)
        else $error("oscillator runs in stop mode");

    AST_LOCKED_WRITE: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (clk_ctl_wr && !unlock_q)
        |=> $stable(clk_sel_q) && $stable(main_fb_off_q))
        else $error("clock control written without unlock");

    AST_PCC_RESET: assert property (@(posedge i_clk)
        $rose(i_resetn) |-> ({sub_fb_off_q, main_osc_stop_q, main_fb_off_q,
                              status_q, clk_sel_q} == PROC_CLK_CTL_RST))
        else $error("clock control reset value wrong");

    AST_PROHIBITED_SEL: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        !(clk_sel_q[3:1] == 3'b011))
        else $error("prohibited clock select stored");

    AST_SWITCH_BOUND: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (i_sub_tick && (status_q != clk_sel_q[CLK_SEL_TOP_BIT]))
        |=> (status_q == $past(clk_sel_q[CLK_SEL_TOP_BIT])))
        else $error("source switch missed subclock pulse");

    AST_HALT_CPU: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (i_power_mode != PWR_RUN) |=> !o_ticks.cpu)
        else $error("cpu clock runs outside run mode");

    AST_SUB_PERIPH: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (status_q && main_osc_stop_q) [*2] |=> (o_ticks.periph == '0))
        else $error("peripheral clock with main stopped");

    AST_SYSTEM_CLOCK_OUT_PIN_LOW: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (i_power_mode inside {PWR_IDLE, PWR_STOP}) |=> !o_system_clock_out_pin)
        else $error("clock output not low while stopped");

    AST_SYSTEM_CLOCK_OUT_PIN_HIZ: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        !i_system_clock_out_pin_enable |=> !o_system_clock_out_pin_oe)
        else $error("clock output driven before configured");

    AST_OST_GATE: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        $fell(osc_on_q) |=> !stable_q [*2])
        else $error("stabilisation not restarted");

    AST_LOOP_READ: assert property (@(posedge i_clk)
        disable iff (!i_resetn)
        (i_req.rd && (i_req.addr == LOOP_CONTROL_ADR))
        |=> (o_rdata[7:3] == 5'h00) && (o_rdata[0] == $past(loop_run_q)))
        else $error("loop control read wrong");

endmodule

`default_nettype wire

// ### testbench/osc_model.sv
// Oscillator model: main and sub crystal edges as one-cycle pulses.
// Assumes one system clock; main crystal swings only while enabled.
`timescale 1ns/100ps
`default_nettype none

module osc_model #(
    parameter int OSC_PER = 12,
    parameter int SUB_PER = 40
) (
    input  wire logic i_clk,
    input  wire logic i_run,
    output logic      o_osc_tick,
    output logic      o_sub_tick
);
    int   osc_cnt = 0;
    int   sub_cnt = 0;
    logic osc_q   = 1'b0;
    logic sub_q   = 1'b0;

    assign o_osc_tick = osc_q;
    assign o_sub_tick = sub_q;

    // ****
    // Main crystal: silent when stopped, restarts its phase
    // ****
    always @(posedge i_clk) begin
        osc_cnt <= (!i_run || osc_cnt == OSC_PER - 1) ? 0 : osc_cnt + 1;
        osc_q   <= i_run && osc_cnt == OSC_PER - 1;
    end

    // ****
    // Subclock crystal runs in every mode
    // ****
    always @(posedge i_clk) begin
        sub_cnt <= (sub_cnt == SUB_PER - 1) ? 0 : sub_cnt + 1;
        sub_q   <= sub_cnt == SUB_PER - 1;
    end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench of the clock generator control.
// Assumes the package and the oscillator model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import clock_gen_pkg::*;

    localparam int OSC_PER = 12;
    localparam int SUB_PER = 40;
    localparam int LIMIT   = 60000;

    logic        i_clk     = 1'b0;
    logic        i_resetn  = 1'b0;
    reg_req_t    req       = '0;
    pwr_mode_t   mode      = PWR_RUN;
    logic        system_clock_out_pin_en = 1'b0;
    logic [7:0]  rdata;
    logic        osc_tick;
    logic        sub_tick;
    logic        osc_run;
    logic        stable;
    logic        loop_on;
    logic        sub_fb;
    logic        main_fb;
    logic        rt_sec;
    logic        system_clock_out_pin;
    logic        system_clock_out_pin_oe;
    clk_ticks_t  ticks;
    logic [14:0] tk;
    int          bad_count   = 0;
    int          comparisons = 0;
    int          cycles      = 0;
    int          cnt [4];
    int          g;
    logic [7:0]  d;

    assign tk = ticks;
    always #10 i_clk = ~i_clk;

    // Oscillator period of 12 cycles keeps the x4 clock on whole cycles
    clock_gen_ctrl #(.OSC_HZ(4_166_667), .OST_COUNT(8)) dut (
        .i_clk                   (i_clk),
        .i_resetn                (i_resetn),
        .i_req                   (req),
        .o_rdata                 (rdata),
        .i_osc_tick              (osc_tick),
        .i_sub_tick              (sub_tick),
        .i_power_mode            (mode),
        .i_system_clock_out_pin_enable         (system_clock_out_pin_en),
        .o_main_osc_run          (osc_run),
        .o_osc_stable            (stable),
        .o_loop_running          (loop_on),
        .o_sub_feedback_off      (sub_fb),
        .o_main_feedback_off     (main_fb),
        .o_realtime_out_security (rt_sec),
        .o_ticks                 (ticks),
        .o_system_clock_out_pin                (system_clock_out_pin),
        .o_system_clock_out_pin_oe             (system_clock_out_pin_oe)
    );

    osc_model #(.OSC_PER(OSC_PER), .SUB_PER(SUB_PER)) osc (
        .i_clk      (i_clk),
        .i_run      (osc_run),
        .o_osc_tick (osc_tick),
        .o_sub_tick (sub_tick)
    );

    // ****
    // Access and check tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [27:0] a, input logic [7:0] v);
        @(posedge i_clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [27:0] a, output logic [7:0] v);
        @(posedge i_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        req.rd <= 1'b0;
        @(negedge i_clk);
        v = rdata;
    endtask

    // Unlock write first, clock control write right after
    task automatic clk_ctl_wr(input logic [7:0] v);
        wr(PROT_CMD_ADR, 8'h00);
        wr(PROC_CLK_CTL_ADR, v);
    endtask

    task automatic gap(input int idx, output int n);
        n = 0;
        // First pulse may still come from the old selection
        repeat (3) begin
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (!tk[idx] && n < 30000);
        end
    endtask

    // Pipeline settles for a few cycles before counting
    task automatic win(input int n);
        cnt = '{default: 0};
        repeat (6) @(negedge i_clk);
        repeat (n) begin
            @(negedge i_clk);
            cnt[0] += int'(tk[14]);
            cnt[1] += int'(tk[13]);
            cnt[2] += int'(tk[12]);
            cnt[3] += int'(system_clock_out_pin);
        end
    endtask

    task automatic wait_stable;
        for (int i = 0; i < 2000 && stable !== 1'b1; i++) @(negedge i_clk);
        chk(16'(stable), 16'h1);
    endtask

    task automatic final_report;
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard well above the longest expected run
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            final_report();
        end
    end

    // ****
    // Test sequence
    // ****
    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        chk(16'(system_clock_out_pin_oe), 16'h0);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'h03);
        rd(LOOP_CONTROL_ADR, d);
        chk(16'(d), 16'h01);
        rd(28'hffff000, d);
        chk(16'(d), 16'h00);
        wr(LOOP_CONTROL_ADR, 8'hfd);
        rd(LOOP_CONTROL_ADR, d);
        chk(16'(d), 16'h05);
        chk(16'(rt_sec), 16'h1);
        wr(PROC_CLK_CTL_ADR, 8'h80);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'h03);
        clk_ctl_wr(8'hb3);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'ha3);
        chk(16'(sub_fb), 16'h1);
        chk(16'(main_fb), 16'h1);
        clk_ctl_wr(8'h06);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'h03);
        wait_stable();
        // Lock wait before multiplying
        repeat (10000) @(posedge i_clk);
        wr(LOOP_CONTROL_ADR, 8'h03);
        repeat (60) @(posedge i_clk);
        chk(16'(loop_on), 16'h1);
        gap(12, g);
        chk(16'(g), 16'(OSC_PER / 4));
        for (int k = 0; k < 6; k++) begin
            clk_ctl_wr(8'(k));
            gap(13, g);
            chk(16'(g), 16'((OSC_PER / 4) << k));
        end
        for (int k = 0; k < 11; k++) begin
            gap(k, g);
            chk(16'(g), 16'((OSC_PER / 4) << k));
        end
        wr(LOOP_CONTROL_ADR, 8'h01);
        repeat (10) @(posedge i_clk);
        wr(LOOP_CONTROL_ADR, 8'h00);
        repeat (3) @(posedge i_clk);
        chk(16'(loop_on), 16'h0);
        clk_ctl_wr(8'h00);
        gap(13, g);
        chk(16'(g), 16'(OSC_PER));
        gap(11, g);
        chk(16'(g >= 1500 && g <= 1560), 16'h1);
        @(posedge i_clk);
        system_clock_out_pin_en <= 1'b1;
        win(100);
        chk(16'(system_clock_out_pin_oe), 16'h1);
        chk(16'(cnt[3] >= 44 && cnt[3] <= 56), 16'h1);
        clk_ctl_wr(8'h40);
        repeat (5) @(posedge i_clk);
        chk(16'(osc_run), 16'h1);
        clk_ctl_wr(8'h00);
        mode <= PWR_HALT;
        win(100);
        chk(16'(cnt[0]), 16'h0);
        chk(16'(cnt[1] > 0 && cnt[2] > 0), 16'h1);
        @(posedge i_clk);
        mode <= PWR_IDLE;
        win(100);
        chk(16'(cnt[1] + cnt[2] + cnt[3]), 16'h0);
        chk(16'(osc_run), 16'h1);
        @(posedge i_clk);
        mode <= PWR_STOP;
        win(20);
        chk(16'(osc_run), 16'h0);
        @(posedge i_clk);
        mode <= PWR_RUN;
        win(2);
        chk(16'(stable), 16'h0);
        wait_stable();
        win(100);
        chk(16'(cnt[0] > 0), 16'h1);
        // Subclock: divider 0 keeps system clock above three subclocks
        clk_ctl_wr(8'h08);
        repeat (SUB_PER + 2) @(posedge i_clk);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'h18);
        gap(13, g);
        chk(16'(g), 16'(SUB_PER));
        clk_ctl_wr(8'h48);
        win(100);
        chk(16'(osc_run), 16'h0);
        chk(16'(cnt[2]), 16'h0);
        chk(16'(cnt[1] > 0 && cnt[0] > 0), 16'h1);
        @(posedge i_clk);
        mode <= PWR_IDLE;
        win(100);
        chk(16'(cnt[0] + cnt[1]), 16'h0);
        @(posedge i_clk);
        mode <= PWR_RUN;
        clk_ctl_wr(8'h08);
        repeat (2) @(posedge i_clk);
        chk(16'(osc_run), 16'h1);
        chk(16'(stable), 16'h0);
        wait_stable();
        clk_ctl_wr(8'h00);
        repeat (SUB_PER + 2) @(posedge i_clk);
        rd(PROC_CLK_CTL_ADR, d);
        chk(16'(d), 16'h00);
        final_report();
    end
endmodule
`default_nettype wire
